/* File: logic/cla_pkg.sv */
// constants, types and reset values of the control location arbiter
`default_nettype none
package cla_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned DEB_TIME_NS = 1000;
  localparam int unsigned DEB_CYC     =
    (DEB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ACK_LOW_MS  = 50;
  localparam int unsigned ACK_LOW_CYC = ACK_LOW_MS * (CLK_HZ / 1000);
  // -------------------------------------------------------------
  // scaling: 26214 steps per full scale
  // -------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE  = 16'h6666;
  localparam logic [15:0] HALF_SCALE  = 16'h3333;
  localparam logic [15:0] LIM_HI_RST  = 16'h6872;
  localparam logic [15:0] LIM_LO_RST  = 16'h0000;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_SET_V  = 5'h08;
  localparam logic [4:0] OFS_SET_I  = 5'h0c;
  localparam logic [4:0] OFS_SET_P  = 5'h10;
  localparam logic [4:0] OFS_LIM_V  = 5'h14;
  localparam logic [4:0] OFS_LIM_I  = 5'h18;
  localparam logic [4:0] OFS_LIM_P  = 5'h1c;
  // control bits
  localparam int CTRL_ALLOW = 0;
  localparam int CTRL_RNG10 = 1;
  localparam int CTRL_REQ   = 2;
  localparam int CTRL_REL   = 3;
  localparam int CTRL_ON    = 4;
  localparam int CTRL_OFF   = 5;
  // status bits
  localparam int ST_LOC     = 0;
  localparam int ST_ON      = 2;
  localparam int ST_ALARM   = 3;
  localparam int ST_ERR     = 4;
  localparam int ST_SUSP    = 5;
  // channels of a set value triple
  localparam int CH_V = 0;
  localparam int CH_I = 1;
  localparam int CH_P = 2;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    CLA_MANUAL  = 2'b00,
    CLA_ANALOG  = 2'b01,
    CLA_DIGITAL = 2'b10,
    CLA_LOCAL   = 2'b11
  } cla_loc_t;
  typedef logic [2:0][15:0] cla_trio_t;
  typedef logic [1:0][15:0] cla_duo_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cla_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cla_wb_rsp_t;
  typedef struct packed {
    cla_loc_t        loc;
    logic            susp;
    logic            allow;
    logic            rng10;
    logic            err;
    logic            out_on;
    logic            alarm;
    logic [1:0]      s1;
    logic [1:0]      s2;
    logic [1:0]      s3;
    logic [1:0]      deb;
    logic [1:0][7:0] dcnt;
    logic [23:0]     lcnt;
    cla_trio_t       host;
    cla_trio_t       lim_lo;
    cla_trio_t       lim_hi;
    cla_trio_t       act;
    cla_duo_t        mon;
    logic [15:0]     vref;
    logic            lind;
    logic            rind;
    logic            ack;
    logic [31:0]     rdat;
  } cla_state_t;
  // pins idle high: unwired remote pin means manual
  localparam cla_state_t CLA_STATE_RST = '{
    loc: CLA_MANUAL, allow: 1'b1, rng10: 1'b1,
    s1: 2'b11, s2: 2'b11, s3: 2'b11, deb: 2'b11,
    lim_lo: {3{LIM_LO_RST}}, lim_hi: {3{LIM_HI_RST}}, vref: FULL_SCALE,
    default: '0};
endpackage
`default_nettype wire

/* File: logic/cla_arbiter.sv */
// control location arbiter with output switching and set value path
// Behaviour
// - one remote source at a time only
// - digital request during analog remote: error
// - remote pin ignored while digital remote
// - status and values always readable
// - inhibit setting forces local, panel only
// - local ends digital remote; host re-requests
// - local suspends analog unless pin rose
// - button toggles output; led shows output
// - standby pin blocks output on always
// - analog takes all three set values
// - analog values shown once analog active
// - range picks 5 V or 10 V scale
// - analog set values clipped to limits
// - remote pin first; standby acts alone
// - 26214 steps per full scale
// - alarm switches output off in analog
// - standby high-low-high, 50ms low, acknowledges
// - digital takeover keeps last set values
// - remote low analog, high or open manual
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cla_arbiter
  import cla_pkg::*;
#(
  parameter int unsigned ACK_CYC = cla_pkg::ACK_LOW_CYC
)(
  input  wire logic             clk_in,          // 200 MHz clock
  input  wire logic             rst_n_in,        // sync reset, low
  input  var  cla_pkg::cla_wb_req_t wb_req_in,   // wishbone request
  output var  cla_pkg::cla_wb_rsp_t wb_rsp_out,  // wishbone answer
  input  wire logic             remote_pin_in,   // low = analog
  input  wire logic             output_standby_pin_in, // low = off
  input  wire logic             panel_button_in, // one-cycle press
  input  wire logic             panel_lock_in,   // panel locked
  input  wire logic             alarm_in,        // device alarm
  input  wire logic             alarm_need_ack_in, // ack required
  input  var  cla_pkg::cla_trio_t knob_set_in,   // knob set values
  input  var  cla_pkg::cla_trio_t analog_port_in, // analog codes
  input  var  cla_pkg::cla_duo_t  actual_in,     // actual v, i
  output var  cla_pkg::cla_trio_t set_value_out, // active, shown
  output logic [15:0]           voltage_monitor_output_out, // v mon
  output logic [15:0]           current_monitor_output_out, // i mon
  output logic [15:0]           vref_code_out,   // reference code
  output logic                  vref_10v_out,    // 10 V range
  output logic                  output_on_out,   // dc output on
  output logic                  on_led_out,      // button led
  output logic                  local_ind_out,   // local shown
  output logic                  remote_ind_out,  // remote shown
  output logic [1:0]            location_out     // location code
);
  import cla_pkg::*;

  // -------------------------------------------------------------
  // state and helpers
  // -------------------------------------------------------------
  localparam logic [23:0] ACK_CNT = 24'(ACK_CYC);
  localparam logic [7:0]  DEB_END = 8'(DEB_CYC - 1);

  cla_state_t  q;
  cla_state_t  n;
  logic        wr;
  logic        req_ev;
  logic        rel_ev;
  logic        on_ev;
  logic        off_ev;
  logic        ack_ev;
  logic        remote_low;
  logic        sb_high;
  logic        want_on;
  logic [16:0] ana_pct;
  cla_trio_t   ana_clip;
  cla_trio_t   knob_clip;
  cla_trio_t   host_clip;

  // clamp a value into [lo, hi]
  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo)
      r = lo;
    if (v > hi)
      r = hi;
    return r;
  endfunction

  // merge write data into a word by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = dat[b*8 +: 8];
    end
    return r;
  endfunction

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    n         = q;
    ana_pct   = '0;
    ana_clip  = '0;
    knob_clip = '0;
    host_clip = '0;
    want_on   = q.out_on;

    // classic wishbone: one ack per request, then a gap cycle
    n.ack  = wb_req_in.cyc & wb_req_in.stb & ~q.ack;
    wr     = n.ack & wb_req_in.we;
    req_ev = wr && wb_req_in.adr == OFS_CTRL && wb_req_in.sel[0]
             && wb_req_in.dat[CTRL_REQ];
    rel_ev = wr && wb_req_in.adr == OFS_CTRL && wb_req_in.sel[0]
             && wb_req_in.dat[CTRL_REL];
    on_ev  = wr && wb_req_in.adr == OFS_CTRL && wb_req_in.sel[0]
             && wb_req_in.dat[CTRL_ON];
    off_ev = wr && wb_req_in.adr == OFS_CTRL && wb_req_in.sel[0]
             && wb_req_in.dat[CTRL_OFF];

    // pin chain: s1 feeds only s2; s2/s3 agreement drives debounce
    n.s1 = {output_standby_pin_in, remote_pin_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int k = 0; k < 2; k++)
    begin
      if (q.s2[k] == q.s3[k] && q.s3[k] != q.deb[k])
      begin
        if (q.dcnt[k] == DEB_END)
        begin
          n.deb[k]  = q.s3[k];
          n.dcnt[k] = '0;
        end
        else
          n.dcnt[k] = q.dcnt[k] + 8'h01;
      end
      else
        n.dcnt[k] = '0;
    end
    remote_low = ~q.deb[0];
    sb_high    = q.deb[1];

    // low phase timer of the standby pin; ack on the rise after it
    ack_ev = sb_high && (q.lcnt == ACK_CNT);
    if (!sb_high)
    begin
      if (q.lcnt != ACK_CNT)
        n.lcnt = q.lcnt + 24'h000001;
    end
    else
      n.lcnt = '0;

    // alarm latch: new alarm wins over an acknowledge
    n.alarm = alarm_in
              | (q.alarm & alarm_need_ack_in & ~ack_ev);

    // register writes; set value writes count only in digital
    if (wr)
    begin
      case (wb_req_in.adr)
        OFS_CTRL:
        begin
          if (wb_req_in.sel[0])
          begin
            n.allow = wb_req_in.dat[CTRL_ALLOW];
            n.rng10 = wb_req_in.dat[CTRL_RNG10];
          end
        end
        OFS_STATUS:
        begin
          if (wb_req_in.sel[0] && wb_req_in.dat[ST_ERR])
            n.err = 1'b0;
        end
        OFS_SET_V, OFS_SET_I, OFS_SET_P:
        begin
          if (q.loc == CLA_DIGITAL)
          begin
            for (int k = 0; k < 3; k++)
            begin
              if (wb_req_in.adr == OFS_SET_V + 5'(4 * k))
                n.host[k] = 16'(merge({16'h0000, q.host[k]},
                                      wb_req_in.dat,
                                      wb_req_in.sel));
            end
          end
        end
        OFS_LIM_V, OFS_LIM_I, OFS_LIM_P:
        begin
          for (int k = 0; k < 3; k++)
          begin
            if (wb_req_in.adr == OFS_LIM_V + 5'(4 * k))
              {n.lim_hi[k], n.lim_lo[k]} =
                merge({q.lim_hi[k], q.lim_lo[k]},
                      wb_req_in.dat, wb_req_in.sel);
          end
          n.lim_lo[CH_P] = '0; // power has an upper limit only
        end
        default:
        begin
        end
      endcase
    end

    // location: at most one remote owner at a time
    case (q.loc)
      CLA_MANUAL:
      begin
        if (!q.allow)
        begin
          n.loc  = CLA_LOCAL;
          n.susp = 1'b0;
        end
        else if (remote_low)
          n.loc = CLA_ANALOG;
        else if (req_ev)
        begin
          n.loc  = CLA_DIGITAL;
          n.host = q.act;
        end
      end
      CLA_ANALOG:
      begin
        if (!q.allow)
        begin
          n.loc  = CLA_LOCAL;
          n.susp = 1'b1;
        end
        else if (!remote_low)
          n.loc = CLA_MANUAL;
      end
      CLA_DIGITAL:
      begin
        // remote pin is not looked at here
        if (!q.allow)
        begin
          n.loc  = CLA_LOCAL;
          n.susp = 1'b0;
        end
        else if (rel_ev)
          n.loc = CLA_MANUAL;
      end
      CLA_LOCAL:
      begin
        // host must request again: no return to digital from here
        if (!remote_low)
          n.susp = 1'b0;
        if (q.allow)
        begin
          n.susp = 1'b0;
          if (q.susp && remote_low)
            n.loc = CLA_ANALOG;
          else
            n.loc = CLA_MANUAL;
        end
      end
      default:
        n.loc = CLA_MANUAL;
    endcase

    // refused request: sticky error, set wins over a clear
    if (req_ev && (q.loc == CLA_ANALOG || q.loc == CLA_LOCAL
                   || (q.loc == CLA_MANUAL && remote_low)))
      n.err = 1'b1;

    // indicators and reference registered so every output is a flop
    n.vref = n.rng10 ? FULL_SCALE : HALF_SCALE;
    n.lind = (n.loc == CLA_LOCAL);
    n.rind = (n.loc == CLA_ANALOG) || (n.loc == CLA_DIGITAL);

    // set value path, per channel
    for (int k = 0; k < 3; k++)
    begin
      // 5 V range doubles the 10 V based code
      ana_pct = q.rng10 ? {1'b0, analog_port_in[k]}
                        : {analog_port_in[k], 1'b0};
      if (ana_pct[16])
        ana_pct = 17'h0ffff;
      ana_clip[k]  = clip(ana_pct[15:0], q.lim_lo[k],
                          q.lim_hi[k]);
      knob_clip[k] = clip(knob_set_in[k], q.lim_lo[k], q.lim_hi[k]);
      host_clip[k] = clip(q.host[k], q.lim_lo[k], q.lim_hi[k]);
    end
    case (q.loc)
      CLA_ANALOG:  n.act = ana_clip;
      CLA_DIGITAL: n.act = host_clip;
      default:     n.act = knob_clip;
    endcase

    // monitor outputs follow the range, 26214 steps full scale
    for (int k = 0; k < 2; k++)
    begin
      n.mon[k] = q.rng10 ? actual_in[k]
                         : {1'b0, actual_in[k][15:1]};
    end

    // output switching per location
    case (q.loc)
      CLA_ANALOG:
        want_on = sb_high;
      CLA_DIGITAL:
      begin
        if (on_ev)
          want_on = 1'b1;
        if (off_ev)
          want_on = 1'b0;
      end
      default:
      begin
        if (panel_button_in && !panel_lock_in)
          want_on = ~q.out_on;
      end
    endcase
    // standby pin and alarms veto the output in every location
    if (!sb_high || alarm_in || q.alarm)
      want_on = 1'b0;
    n.out_on = want_on;

    // read data, valid with ack; reads work in every location
    n.rdat = '0;
    if (n.ack && !wb_req_in.we)
    begin
      case (wb_req_in.adr)
        OFS_CTRL:
        begin
          n.rdat[CTRL_ALLOW] = q.allow;
          n.rdat[CTRL_RNG10] = q.rng10;
        end
        OFS_STATUS:
        begin
          n.rdat[ST_LOC +: 2] = q.loc;
          n.rdat[ST_ON]       = q.out_on;
          n.rdat[ST_ALARM]    = q.alarm;
          n.rdat[ST_ERR]      = q.err;
          n.rdat[ST_SUSP]     = q.susp;
        end
        OFS_SET_V: n.rdat[15:0] = q.act[CH_V];
        OFS_SET_I: n.rdat[15:0] = q.act[CH_I];
        OFS_SET_P: n.rdat[15:0] = q.act[CH_P];
        OFS_LIM_V: n.rdat = {q.lim_hi[CH_V], q.lim_lo[CH_V]};
        OFS_LIM_I: n.rdat = {q.lim_hi[CH_I], q.lim_lo[CH_I]};
        OFS_LIM_P: n.rdat = {q.lim_hi[CH_P], q.lim_lo[CH_P]};
        default:   n.rdat = '0;
      endcase
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      q <= CLA_STATE_RST;
    else
      q <= n;
  end

  // -------------------------------------------------------------
  // outputs, all from the state register
  // -------------------------------------------------------------
  assign wb_rsp_out.ack             = q.ack;
  assign wb_rsp_out.dat             = q.rdat;
  assign set_value_out              = q.act;
  assign voltage_monitor_output_out = q.mon[CH_V];
  assign current_monitor_output_out = q.mon[CH_I];
  assign vref_code_out = q.vref;
  assign vref_10v_out  = q.rng10;
  assign output_on_out = q.out_on;
  assign on_led_out    = q.out_on;
  assign local_ind_out = q.lind;
  assign remote_ind_out = q.rind;
  assign location_out  = q.loc;
endmodule // cla_arbiter
`default_nettype wire

/* File: dv/cla_arbiter_asserts.sv */
// port assertions of the control location arbiter
`timescale 1ns/100ps
`default_nettype none
module cla_arbiter_asserts
  import cla_pkg::*;
(
  input wire logic          clk_in,         // clock
  input wire logic          rst_n_in,       // sync reset, low
  input var cla_pkg::cla_wb_req_t wb_req_in, // bus request
  input var cla_pkg::cla_wb_rsp_t wb_rsp_out, // bus answer
  input wire logic          alarm_in,       // device alarm
  input wire logic [15:0]   vref_code_out,  // reference code
  input wire logic          vref_10v_out,   // 10 V range
  input wire logic          output_on_out,  // output on
  input wire logic          on_led_out,     // button led
  input wire logic          local_ind_out,  // local shown
  input wire logic          remote_ind_out, // remote shown
  input wire logic [1:0]    location_out    // location code
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------
  // bus handshake
  // ----------------------------
  sequence taken_s;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence answer_s;
    wb_rsp_out.ack ##1 !wb_rsp_out.ack;
  endsequence
  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("request not answered in one cycle");
  idle_data_a: assert property (!wb_rsp_out.ack |->
    wb_rsp_out.dat == '0)
    else $error("read data outside ack cycle");
  // ----------------------------
  // location and output
  // ----------------------------
  led_match_a: assert property (on_led_out == output_on_out)
    else $error("led differs from output");
  alarm_off_a: assert property (alarm_in |=> !output_on_out)
    else $error("output on during alarm");
  vref_scale_a: assert property (vref_code_out ==
    (vref_10v_out ? FULL_SCALE : HALF_SCALE))
    else $error("reference code wrong for range");
  local_shown_a: assert property (local_ind_out ==
    (location_out == CLA_LOCAL))
    else $error("local indicator wrong");
  remote_shown_a: assert property (remote_ind_out ==
    (location_out == CLA_ANALOG || location_out == CLA_DIGITAL))
    else $error("remote indicator wrong");
  analog_keep_a: assert property ((location_out == CLA_ANALOG)
    |=> (location_out != CLA_DIGITAL))
    else $error("analog handed straight to digital");
  digital_keep_a: assert property ((location_out == CLA_DIGITAL)
    |=> (location_out != CLA_ANALOG))
    else $error("pin took over digital remote");
  local_exit_a: assert property ((location_out == CLA_LOCAL)
    |=> (location_out != CLA_DIGITAL))
    else $error("digital resumed without request");
endmodule // cla_arbiter_asserts
bind cla_arbiter cla_arbiter_asserts cla_arbiter_asserts_inst (
  .clk_in, .rst_n_in, .wb_req_in, .wb_rsp_out, .alarm_in,
  .vref_code_out, .vref_10v_out, .output_on_out, .on_led_out,
  .local_ind_out, .remote_ind_out, .location_out);
`default_nettype wire

/* File: dv/cla_ctl_model.sv */
// analog controller model driving the remote and standby pins
`timescale 1ns/100ps
`default_nettype none
module cla_ctl_model (
  input  wire logic clk_in,                 // clock
  input  wire logic analog_in,              // ask for analog remote
  input  wire logic standby_in,             // hold output off
  output logic      remote_pin_out = 1'b1,  // low = analog
  output logic      standby_pin_out = 1'b1  // low = off
);
  // open collector to ground: a released pin floats high
  always @(posedge clk_in)
  begin
    remote_pin_out  <= !analog_in;
    standby_pin_out <= !standby_in;
  end
endmodule // cla_ctl_model
`default_nettype wire

/* File: dv/control_location_arbiter_test.sv */
// self-checking bench of the control location arbiter
`timescale 1ns/100ps
`default_nettype none
module control_location_arbiter_test;
  import cla_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, rpin, spin;
  logic        want_an = 1'b0, want_sb = 1'b0, btn = 1'b0;
  logic        lock = 1'b0, alarm = 1'b0, need_ack = 1'b0;
  cla_wb_req_t req = '0;
  cla_wb_rsp_t rsp;
  cla_trio_t   knob = '0, ain = '0, setv, exp_set, tmp;
  cla_duo_t    act = '0;
  logic [15:0] voltage_monitor_output, imon, vref;
  logic        v10, on, led, lind, rind;
  logic [1:0]  loc;
  logic [31:0] r;
  int          fail_count = 0, compares = 0;
  cla_arbiter #(.ACK_CYC(400)) cla_arbiter_inst (
    .clk_in(clk), .rst_n_in(rst_n), .wb_req_in(req), .wb_rsp_out(rsp),
    .remote_pin_in(rpin), .output_standby_pin_in(spin),
    .panel_button_in(btn), .panel_lock_in(lock), .alarm_in(alarm),
    .alarm_need_ack_in(need_ack), .knob_set_in(knob),
    .analog_port_in(ain), .actual_in(act), .set_value_out(setv),
    .voltage_monitor_output_out(voltage_monitor_output), .current_monitor_output_out(imon),
    .vref_code_out(vref), .vref_10v_out(v10), .output_on_out(on),
    .on_led_out(led), .local_ind_out(lind), .remote_ind_out(rind),
    .location_out(loc));
  cla_ctl_model cla_ctl_model_inst (.clk_in(clk), .analog_in(want_an),
    .standby_in(want_sb), .remote_pin_out(rpin), .standby_pin_out(spin));
  // 200 MHz clock
  always #2.5 clk = !clk;
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic ck(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [4:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 40);
    if (n == 40)
      ck(48'h0, 48'h1);
    r = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    ck(r, e);
  endtask
  task automatic wloc(input logic [1:0] e);
    int n;
    n = 0;
    while (loc !== e && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    ck(loc, e);
  endtask
  task automatic press();
    btn <= 1'b1;
    @(posedge clk);
    btn <= 1'b0;
    cyc(3);
  endtask
  function automatic logic [15:0] clip(input int v);
    return 16'((v > 'h6872) ? 'h6872 : v);
  endfunction
  // main sequence
  initial
  begin
    void'($urandom(2639));
    cyc(5);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, 32'h3);
    rd(OFS_STATUS, 32'h0);
    for (int i = 0; i < 3; i++)
      tmp[i] = 16'($urandom_range(26214));
    knob <= tmp;
    act <= tmp[1:0];
    cyc(4);
    ck(setv, tmp);
    ck({voltage_monitor_output, imon}, {tmp[0], tmp[1]});
    press();
    ck({on, led}, 2'b11);
    lock <= 1'b1;
    press();
    ck(on, 1'b1);
    lock <= 1'b0;
    press();
    ck({on, led}, 2'b00);
    want_sb <= 1'b1;
    cyc(250);
    press();
    ck(on, 1'b0);
    want_sb <= 1'b0;
    cyc(250);
    exp_set = setv;
    wb(1'b1, OFS_CTRL, 32'h7);
    wloc(CLA_DIGITAL);
    ck(setv, exp_set);
    exp_set[CH_V] = 16'($urandom_range(26214));
    wb(1'b1, OFS_SET_V, {16'h0, exp_set[CH_V]});
    rd(OFS_SET_V, {16'h0, exp_set[CH_V]});
    wb(1'b1, OFS_CTRL, 32'h13);
    cyc(2);
    ck(on, 1'b1);
    wb(1'b1, OFS_CTRL, 32'h2);
    wloc(CLA_LOCAL);
    ck({lind, rind}, 2'b10);
    wb(1'b1, OFS_CTRL, 32'h3);
    wloc(CLA_MANUAL);
    wb(1'b1, OFS_CTRL, 32'h7);
    wloc(CLA_DIGITAL);
    want_an <= 1'b1;
    cyc(250);
    ck(loc, CLA_DIGITAL);
    wb(1'b1, OFS_CTRL, 32'hb);
    wloc(CLA_ANALOG);
    cyc(2);
    ck(setv, 48'h0);
    ck({lind, rind}, 2'b01);
    wb(1'b1, OFS_CTRL, 32'h7);
    rd(OFS_STATUS, 32'h15);
    wb(1'b1, OFS_STATUS, 32'h10);
    // both ranges, random analog codes, 5 V codes doubled then clipped
    for (int k = 1; k >= 0; k--)
    begin
      wb(1'b1, OFS_CTRL, {30'h0, k[0], 1'b1});
      for (int i = 0; i < 3; i++)
        tmp[i] = 16'($urandom_range(26214));
      ain <= tmp;
      cyc(4);
      for (int i = 0; i < 3; i++)
        ck(setv[i], clip(k ? tmp[i] : 2 * tmp[i]));
      ck(vref, k ? FULL_SCALE : HALF_SCALE);
      ck(v10, k[0]);
      ck(voltage_monitor_output, k ? act[0] : act[0] / 2);
    end
    wb(1'b1, OFS_CTRL, 32'h3);
    wb(1'b1, OFS_LIM_V, 32'h5000_0400);
    ain[CH_V] <= 16'h0100;
    cyc(4);
    ck(setv[CH_V], 16'h0400);
    ain[CH_V] <= 16'h7fff;
    cyc(4);
    ck(setv[CH_V], 16'h5000);
    wb(1'b1, OFS_CTRL, 32'h2);
    wloc(CLA_LOCAL);
    wb(1'b1, OFS_CTRL, 32'h3);
    wloc(CLA_ANALOG);
    wb(1'b1, OFS_CTRL, 32'h2);
    want_an <= 1'b0;
    cyc(250);
    wb(1'b1, OFS_CTRL, 32'h3);
    cyc(2);
    ck(loc, CLA_MANUAL);
    want_an <= 1'b1;
    wloc(CLA_ANALOG);
    cyc(2);
    ck(on, 1'b1);
    alarm <= 1'b1;
    need_ack <= 1'b1;
    cyc(2);
    ck(on, 1'b0);
    alarm <= 1'b0;
    cyc(2);
    rd(OFS_STATUS, 32'h09);
    // low phase shorter than the acknowledge time: alarm must stay
    want_sb <= 1'b1;
    cyc(260);
    want_sb <= 1'b0;
    cyc(250);
    rd(OFS_STATUS, 32'h09);
    want_sb <= 1'b1;
    cyc(650);
    want_sb <= 1'b0;
    cyc(250);
    rd(OFS_STATUS, 32'h05);
    // a short dip is below the debounce time and changes nothing
    want_sb <= 1'b1;
    cyc(20);
    want_sb <= 1'b0;
    cyc(250);
    ck(on, 1'b1);
    close_out();
  end
  // watchdog well past the expected run
  initial
  begin
    #100_000;
    fail_count++;
    close_out();
  end
endmodule // control_location_arbiter_test
`default_nettype wire
